//--- common/ctlp_pkg.sv
// Behaviour
// - Retired pc and instruction shown, meaningful only with retire valid
// - Data address shown, meaningful only while load or store strobe is high
// - With register write strobe, show written register index and new value
// - Exception kind separates interrupt, break, exception; meaningful only when taken
// - Trace signals always produced once enabled, attached or not; here a record reaches trace_out the cycle after trace_ready is high, zero otherwise
// - Both lockstep cores run the same program; outside logic compares outputs
// - Lockstep off: no lockstep ports carry anything
// - Primary mode: primary bundle for the shadow plus compare bundle
// - Shadow mode: follow bundle in, compare bundle out, shadow parameter is 1
// - Visible shadow is exposed as processor, may own private local memory
// - Hidden shadow equals visible shadow but is not exposed as processor
// - Hidden shadow local-memory monitors observe the primary's local traffic
// - Hidden shadow AXI monitors observe the primary's AXI transactions
// - Interrupt monitor lets a shadow observe the primary's shared interrupt
// - AXI selection: all AXI; ACE selection: peripheral AXI, cache ACE
// - ACE only without area opt, write-back, streams; 32-bit victims; caches always
// - Peripheral data uses AXI4-Lite, full AXI4 with exclusive access
// - Each stream link is one master and one slave stream interface
// - Data local memory bus carries data and exception vectors when enabled
package ctlp_pkg;
    localparam int XLEN         = 32;
    localparam int REG_IDX_W    = 5;
    localparam int EXC_KIND_W   = 5;
    localparam int FIFO_DEPTH   = 8;
    localparam int VICTIM_W_ACE = 32;

    typedef enum logic [1:0] {LS_NONE, LS_PRIMARY, LS_SHADOW, LS_HIDDEN} ctlp_ls_mode_t;
    typedef enum logic {BUS_AXI, BUS_ACE} ctlp_bus_sel_t;

    typedef struct packed {
        logic                  valid;
        logic [XLEN-1:0]       pc;
        logic [XLEN-1:0]       instr;
        logic                  rd;
        logic                  wr;
        logic [XLEN-1:0]       data_addr;
        logic                  reg_wr;
        logic [REG_IDX_W-1:0]  reg_idx;
        logic [XLEN-1:0]       reg_val;
        logic                  exc_taken;
        logic [EXC_KIND_W-1:0] exc_kind;
    } ctlp_retire_t;

    typedef struct packed {
        logic                  valid;
        logic [XLEN-1:0]       pc;
        logic                  rd;
        logic                  wr;
        logic [XLEN-1:0]       data_addr;
        logic                  reg_wr;
        logic [XLEN-1:0]       reg_val;
        logic                  exc_taken;
        logic [EXC_KIND_W-1:0] exc_kind;
    } ctlp_cmp_t;

    typedef struct packed {
        logic            valid;
        logic [XLEN-1:0] data;
    } ctlp_chan_t;

    typedef struct packed {
        logic       irq;
        ctlp_chan_t local_memory_bus_i;
        ctlp_chan_t local_memory_bus_d;
        ctlp_chan_t axi_pi;
        ctlp_chan_t axi_pd;
        ctlp_chan_t axi_ci;
        ctlp_chan_t axi_cd;
    } ctlp_follow_t;

    localparam int RETIRE_W = $bits(ctlp_retire_t);
endpackage

//--- dv/ctlp_trace_sink.sv
`timescale 1ns/1ps

// ----------------------------------------
// Trace capture stand-in
// ----------------------------------------
// Backpressures at random, never kinder than a real capture core
module ctlp_trace_sink (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   stall_all,
    input  wire ctlp_pkg::ctlp_retire_t trace_out,
    output logic                        trace_ready,
    output int                          seen_cnt
);
    import ctlp_pkg::*;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            seen_cnt <= 0;
        end else if (trace_out.valid) begin
            seen_cnt <= seen_cnt + 1;
        end
        #1;
        trace_ready = !stall_all && ($urandom % 4 != 0);
    end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import ctlp_pkg::*;

    localparam int CW = 256;

    logic                  ref_clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  stall_all = 1'b0;
    ctlp_retire_t          retire_in = '0;
    logic                  retire_ready;
    ctlp_retire_t          trace_out;
    logic                  trace_ready;
    ctlp_follow_t          own_in = '0;
    ctlp_follow_t          core_in;
    ctlp_follow_t          primary_out;
    ctlp_cmp_t             compare_out;
    ctlp_follow_t          sh_core_in;
    ctlp_follow_t          sh_primary_out;
    ctlp_cmp_t             sh_compare_out;
    wire [5:0]             cfg;
    wire [5:0]             sh_cfg;
    logic [0:0]            put_valid = '0;
    logic [0:0][XLEN-1:0]  put_data = '0;
    logic [0:0]            put_ready;
    logic [0:0]            m_axis_tvalid;
    logic [0:0][XLEN-1:0]  m_axis_tdata;
    logic [0:0]            m_axis_tready = '0;
    logic [0:0]            s_axis_tvalid = '0;
    logic [0:0][XLEN-1:0]  s_axis_tdata = '0;
    logic [0:0]            s_axis_tready;
    logic [0:0]            get_valid;
    logic [0:0][XLEN-1:0]  get_data;
    logic [0:0]            get_ready = '0;
    int                    seen_cnt;
    int                    error_cnt = 0;
    int                    tests_run = 0;
    int                    offer = 0;
    int                    acc_cnt = 0;
    int                    total_acc = 0;
    int                    cyc = 0;
    bit                    live = 0;
    bit                    seeded = 0;
    bit                    ret_taken = 0;
    bit                    put_taken = 0;
    bit                    s_taken = 0;
    ctlp_cmp_t             cmp_exp = '0;
    ctlp_follow_t          own_prev = '0;
    ctlp_follow_t          own_prev2 = '0;
    ctlp_follow_t          sh_exp;
    ctlp_retire_t          exp_q[$];
    logic [XLEN-1:0]       put_q[$];
    logic [XLEN-1:0]       get_q[$];
    logic [223:0]          rnd;
    ctlp_retire_t          r;

    always #5 ref_clk = ~ref_clk;

    ctlp_trace_lockstep #(.LS_MODE(LS_PRIMARY), .STREAM_LINKS(1)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .retire_in(retire_in), .retire_ready(retire_ready),
        .trace_out(trace_out), .trace_ready(trace_ready), .own_in(own_in), .follow_in('0),
        .core_in(core_in), .primary_out(primary_out), .compare_out(compare_out),
        .shadow_core_param(cfg[0]), .exposed_as_processor(cfg[1]), .cache_bus_ace(cfg[2]),
        .ace_config_error(cfg[3]), .periph_full_axi4(cfg[4]),
        .vectors_on_local_memory_bus(cfg[5]), .put_valid(put_valid), .put_data(put_data),
        .put_ready(put_ready), .m_axis_tvalid(m_axis_tvalid), .m_axis_tdata(m_axis_tdata),
        .m_axis_tready(m_axis_tready), .s_axis_tvalid(s_axis_tvalid), .s_axis_tdata(s_axis_tdata),
        .s_axis_tready(s_axis_tready), .get_valid(get_valid), .get_data(get_data), .get_ready(get_ready)
    );

    ctlp_trace_lockstep #(.LS_MODE(LS_HIDDEN), .BUS_SEL(BUS_ACE), .MON_IRQ(1'b1), .MON_AXI_CD(1'b1),
        .MON_LOCAL_MEMORY_BUS_D(1'b1), .EXCLUSIVE_ACCESS(1'b1), .DATA_LOCAL_MEMORY_BUS_EN(1'b0)) dut_shadow (
        .ref_clk(ref_clk), .rst_n(rst_n), .retire_in(retire_in), .retire_ready(), .trace_out(),
        .trace_ready(trace_ready), .own_in(own_in), .follow_in(primary_out), .core_in(sh_core_in),
        .primary_out(sh_primary_out), .compare_out(sh_compare_out), .shadow_core_param(sh_cfg[0]),
        .exposed_as_processor(sh_cfg[1]), .cache_bus_ace(sh_cfg[2]), .ace_config_error(sh_cfg[3]),
        .periph_full_axi4(sh_cfg[4]), .vectors_on_local_memory_bus(sh_cfg[5]), .put_valid('0),
        .put_data('0), .put_ready(), .m_axis_tvalid(), .m_axis_tdata(), .m_axis_tready('0),
        .s_axis_tvalid('0), .s_axis_tdata('0), .s_axis_tready(), .get_valid(), .get_data(), .get_ready('0)
    );

    ctlp_trace_sink sink (
        .ref_clk(ref_clk), .rst_n(rst_n), .stall_all(stall_all), .trace_out(trace_out),
        .trace_ready(trace_ready), .seen_cnt(seen_cnt)
    );

    // ----------------------------------------
    // Reference model helpers
    // ----------------------------------------
    task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Unqualified fields read as zero on the trace
    function automatic ctlp_retire_t mask(ctlp_retire_t m);
        if (!m.valid) m.pc = '0;
        if (!(m.rd || m.wr)) m.data_addr = '0;
        if (!m.reg_wr) begin
            m.reg_idx = '0;
            m.reg_val = '0;
        end
        if (!m.exc_taken) m.exc_kind = '0;
        return m;
    endfunction

    function automatic ctlp_cmp_t to_cmp(ctlp_retire_t m);
        ctlp_cmp_t c;
        c = '{m.valid, m.pc, m.rd, m.wr, m.data_addr, m.reg_wr, m.reg_val, m.exc_taken, m.exc_kind};
        return c;
    endfunction

    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Monitor: sampled before the edge lands
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            live = 0;
            ret_taken = 0;
            put_taken = 0;
            s_taken = 0;
        end else begin
            if (live) begin
                sh_exp = own_prev;
                sh_exp.irq = own_prev2.irq;
                sh_exp.local_memory_bus_d = own_prev2.local_memory_bus_d;
                sh_exp.axi_cd = own_prev2.axi_cd;
                chk(CW'(primary_out), CW'(own_prev));
                chk(CW'(core_in), CW'(own_prev));
                chk(CW'(compare_out), CW'(cmp_exp));
                chk(CW'(sh_core_in), CW'(sh_exp));
                chk(CW'(sh_compare_out), CW'(cmp_exp));
                chk(CW'(sh_primary_out), 0);
                if (!trace_out.valid) chk(CW'(trace_out), '0);
                else if (exp_q.size() > 0) chk(CW'(trace_out), CW'(exp_q.pop_front()));
                else chk(1, 0);
                if (m_axis_tvalid[0] && m_axis_tready[0]) begin
                    if (put_q.size() > 0) chk(CW'(m_axis_tdata[0]), CW'(put_q.pop_front()));
                    else chk(1, 0);
                end
                if (get_valid[0] && get_ready[0]) begin
                    if (get_q.size() > 0) chk(CW'(get_data[0]), CW'(get_q.pop_front()));
                    else chk(1, 0);
                end
            end
            ret_taken = retire_in.valid && retire_ready;
            cmp_exp = to_cmp(mask(retire_in));
            cmp_exp.valid = ret_taken;
            if (ret_taken) begin
                exp_q.push_back(mask(retire_in));
                acc_cnt++;
                total_acc++;
            end
            put_taken = put_valid[0] && put_ready[0];
            if (put_taken) put_q.push_back(put_data[0]);
            s_taken = s_axis_tvalid[0] && s_axis_tready[0];
            if (s_taken) get_q.push_back(s_axis_tdata[0]);
            own_prev2 = own_prev;
            own_prev = own_in;
            live = 1;
        end
    end

    // ----------------------------------------
    // Drivers: refused requests are held
    // ----------------------------------------
    always begin
        if (!seeded) begin
            void'($urandom(32'h40de7b35));
            seeded = 1;
        end
        @(posedge ref_clk);
        #1;
        if (rst_n) begin
            if (!(retire_in.valid && !ret_taken)) begin
                r = '0;
                r.pc = $urandom;
                r.instr = $urandom;
                r.data_addr = $urandom;
                r.reg_idx = 5'($urandom);
                r.reg_val = $urandom;
                r.exc_kind = 5'($urandom);
                r.valid = (offer == 2) || (offer == 1 && $urandom % 2 == 1);
                if (r.valid) begin
                    r.rd = 1'($urandom);
                    r.wr = 1'($urandom);
                    r.reg_wr = 1'($urandom);
                    r.exc_taken = ($urandom % 4 == 0);
                end
                retire_in = r;
            end
            if (!(put_valid[0] && !put_taken)) begin
                put_valid = 1'($urandom);
                put_data = $urandom;
            end
            if (!(s_axis_tvalid[0] && !s_taken)) begin
                s_axis_tvalid = 1'($urandom);
                s_axis_tdata = $urandom;
            end
            m_axis_tready = 1'($urandom);
            get_ready = ($urandom % 3 != 0);
            rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            own_in = rnd[$bits(ctlp_follow_t)-1:0];
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        chk(CW'(retire_ready), 1);
        chk(CW'(trace_out), '0);
        chk(CW'(compare_out), '0);
        rst_n = 1'b1;
        chk(CW'(cfg[0]), 0);
        chk(CW'(cfg[1]), 1);
        chk(CW'(cfg[2]), 0);
        chk(CW'(cfg[3]), 0);
        chk(CW'(cfg[4]), 0);
        chk(CW'(cfg[5]), 1);
        chk(CW'(sh_cfg), CW'(6'h15));
        @(negedge ref_clk);
        offer = 1;
        repeat (400) @(negedge ref_clk);
        offer = 0;
        repeat (40) @(negedge ref_clk);
        // Full stall: buffer must take exactly its depth, then refuse
        stall_all = 1'b1;
        repeat (3) @(negedge ref_clk);
        acc_cnt = 0;
        offer = 2;
        repeat (25) @(negedge ref_clk);
        chk(CW'(acc_cnt), CW'(FIFO_DEPTH));
        stall_all = 1'b0;
        offer = 1;
        repeat (300) @(negedge ref_clk);
        offer = 0;
        repeat (80) @(negedge ref_clk);
        chk(CW'(exp_q.size()), 0);
        chk(CW'(seen_cnt), CW'(total_acc));
        summarize();
    end
endmodule

//--- verilog/ctlp_trace_lockstep.sv
`timescale 1ns/1ps

// ----------------------------------------
// Buffer between retire stream and trace
// ----------------------------------------
// Depth must be a power of two; pointers wrap by overflow.
module ctlp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output wire logic         in_ready,
    output wire logic         out_valid,
    output wire logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } ctlp_fifo_st_t;

    ctlp_fifo_st_t st_q;
    ctlp_fifo_st_t st_d;
    logic          push;
    logic          pop;

    assign in_ready  = st_q.cnt != FULL;
    assign out_valid = st_q.cnt != '0;
    assign out_data  = st_q.mem[st_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = in_data;
            st_d.wp           = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    a_fifo_full_stall: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q.cnt <= FULL)
        else $error("fifo accepts while full");
endmodule

// ----------------------------------------
// One-entry register slice for streams
// ----------------------------------------
module ctlp_stage #(
    parameter int W = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output wire logic         in_ready,
    output wire logic         out_valid,
    output wire logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    typedef struct packed {
        logic         v;
        logic [W-1:0] data;
    } ctlp_stage_st_t;

    ctlp_stage_st_t st_q;
    ctlp_stage_st_t st_d;

    assign in_ready  = !st_q.v || out_ready;
    assign out_valid = st_q.v;
    assign out_data  = st_q.data;

    always_comb begin
        st_d = st_q;
        if (out_ready) begin
            st_d.v = 1'b0;
        end
        if (in_valid && in_ready) begin
            st_d.v    = 1'b1;
            st_d.data = in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ----------------------------------------
// Trace, lockstep and bus option ports
// ----------------------------------------
module ctlp_trace_lockstep #(
    parameter ctlp_pkg::ctlp_ls_mode_t LS_MODE      = ctlp_pkg::LS_NONE,
    parameter ctlp_pkg::ctlp_bus_sel_t BUS_SEL      = ctlp_pkg::BUS_AXI,
    parameter bit  MON_LOCAL_MEMORY_BUS_I           = 1'b0,
    parameter bit  MON_LOCAL_MEMORY_BUS_D           = 1'b0,
    parameter bit  MON_AXI_PI                       = 1'b0,
    parameter bit  MON_AXI_PD                       = 1'b0,
    parameter bit  MON_AXI_CI                       = 1'b0,
    parameter bit  MON_AXI_CD                       = 1'b0,
    parameter bit  MON_IRQ                          = 1'b0,
    parameter bit  AREA_OPT                         = 1'b0,
    parameter bit  WB_DCACHE                        = 1'b0,
    parameter bit  ICACHE_STREAMS                   = 1'b0,
    parameter int  VICTIM_W                         = 32,
    parameter bit  ICACHE_FOR_ALL_ACCESSES          = 1'b1,
    parameter bit  DCACHE_FOR_ALL_ACCESSES          = 1'b1,
    parameter bit  EXCLUSIVE_ACCESS                 = 1'b0,
    parameter bit  DATA_LOCAL_MEMORY_BUS_EN         = 1'b1,
    parameter int  STREAM_LINKS                     = 1,
    parameter int  FIFO_D                           = ctlp_pkg::FIFO_DEPTH
) (
    input  wire logic                                        ref_clk,
    input  wire logic                                        rst_n,
    input  wire ctlp_pkg::ctlp_retire_t                      retire_in,
    output wire logic                                        retire_ready,
    output wire ctlp_pkg::ctlp_retire_t                      trace_out,
    input  wire logic                                        trace_ready,
    input  wire ctlp_pkg::ctlp_follow_t                      own_in,
    input  wire ctlp_pkg::ctlp_follow_t                      follow_in,
    output wire ctlp_pkg::ctlp_follow_t                      core_in,
    output wire ctlp_pkg::ctlp_follow_t                      primary_out,
    output wire ctlp_pkg::ctlp_cmp_t                         compare_out,
    output wire logic                                        shadow_core_param,
    output wire logic                                        exposed_as_processor,
    output wire logic                                        cache_bus_ace,
    output wire logic                                        ace_config_error,
    output wire logic                                        periph_full_axi4,
    output wire logic                                        vectors_on_local_memory_bus,
    input  wire logic [STREAM_LINKS-1:0]                     put_valid,
    input  wire logic [STREAM_LINKS-1:0][ctlp_pkg::XLEN-1:0] put_data,
    output wire logic [STREAM_LINKS-1:0]                     put_ready,
    output wire logic [STREAM_LINKS-1:0]                     m_axis_tvalid,
    output wire logic [STREAM_LINKS-1:0][ctlp_pkg::XLEN-1:0] m_axis_tdata,
    input  wire logic [STREAM_LINKS-1:0]                     m_axis_tready,
    input  wire logic [STREAM_LINKS-1:0]                     s_axis_tvalid,
    input  wire logic [STREAM_LINKS-1:0][ctlp_pkg::XLEN-1:0] s_axis_tdata,
    output wire logic [STREAM_LINKS-1:0]                     s_axis_tready,
    output wire logic [STREAM_LINKS-1:0]                     get_valid,
    output wire logic [STREAM_LINKS-1:0][ctlp_pkg::XLEN-1:0] get_data,
    input  wire logic [STREAM_LINKS-1:0]                     get_ready
);
    import ctlp_pkg::*;

    localparam bit IS_SHADOW = LS_MODE == LS_SHADOW || LS_MODE == LS_HIDDEN;
    localparam bit IS_HIDDEN = LS_MODE == LS_HIDDEN;
    localparam bit ACE_OK    = !AREA_OPT && !WB_DCACHE && !ICACHE_STREAMS && VICTIM_W == VICTIM_W_ACE
                               && ICACHE_FOR_ALL_ACCESSES && DCACHE_FOR_ALL_ACCESSES;

    typedef struct packed {
        ctlp_retire_t trace;
        ctlp_cmp_t    cmp;
        ctlp_follow_t prim;
        ctlp_follow_t core;
    } ctlp_state_t;

    ctlp_state_t  st_q;
    ctlp_state_t  st_d;
    ctlp_retire_t masked;
    logic         fifo_valid;
    logic [RETIRE_W-1:0] fifo_data;

    // ----------------------------------------
    // Qualifying strobes
    // ----------------------------------------
    // Unqualified fields are zeroed so capture never sees stale values.
    function automatic ctlp_retire_t mask_retire(input ctlp_retire_t r);
        ctlp_retire_t m;
        m = r;
        if (!r.valid) begin
            m.pc    = '0;
            m.instr = '0;
        end
        if (!(r.rd || r.wr)) begin
            m.data_addr = '0;
        end
        if (!r.reg_wr) begin
            m.reg_idx = '0;
            m.reg_val = '0;
        end
        if (!r.exc_taken) begin
            m.exc_kind = '0;
        end
        return m;
    endfunction

    function automatic ctlp_chan_t pick(input ctlp_chan_t own, input ctlp_chan_t fol, input bit mon);
        return mon ? fol : own;
    endfunction

    assign masked = mask_retire(retire_in);

    // Full buffer stalls the core rather than dropping trace records
    ctlp_fifo #(
        .W (RETIRE_W),
        .D (FIFO_D)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (masked.valid),
        .in_data   (masked),
        .in_ready  (retire_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (trace_ready)
    );

    // ----------------------------------------
    // State update
    // ----------------------------------------
    always_comb begin
        st_d       = '0;
        st_d.trace = (fifo_valid && trace_ready) ? ctlp_retire_t'(fifo_data) : '0;
        if (LS_MODE != LS_NONE) begin
            // Compare from the core directly, not from the stallable trace path
            st_d.cmp.valid     = masked.valid && retire_ready;
            st_d.cmp.pc        = masked.pc;
            st_d.cmp.rd        = masked.rd;
            st_d.cmp.wr        = masked.wr;
            st_d.cmp.data_addr = masked.data_addr;
            st_d.cmp.reg_wr    = masked.reg_wr;
            st_d.cmp.reg_val   = masked.reg_val;
            st_d.cmp.exc_taken = masked.exc_taken;
            st_d.cmp.exc_kind  = masked.exc_kind;
        end
        if (LS_MODE == LS_PRIMARY) begin
            st_d.prim = own_in;
        end
        // Core inputs arrive one cycle late; shadow monitored fields come via follow_in, two cycles behind own_in
        st_d.core        = own_in;
        st_d.core.irq    = (IS_SHADOW && MON_IRQ) ? follow_in.irq : own_in.irq;
        st_d.core.local_memory_bus_i = pick(own_in.local_memory_bus_i, follow_in.local_memory_bus_i,
                                            IS_HIDDEN && MON_LOCAL_MEMORY_BUS_I);
        st_d.core.local_memory_bus_d = pick(own_in.local_memory_bus_d, follow_in.local_memory_bus_d,
                                            IS_HIDDEN && MON_LOCAL_MEMORY_BUS_D);
        st_d.core.axi_pi = pick(own_in.axi_pi, follow_in.axi_pi, IS_HIDDEN && MON_AXI_PI);
        st_d.core.axi_pd = pick(own_in.axi_pd, follow_in.axi_pd, IS_HIDDEN && MON_AXI_PD);
        st_d.core.axi_ci = pick(own_in.axi_ci, follow_in.axi_ci, IS_HIDDEN && MON_AXI_CI);
        st_d.core.axi_cd = pick(own_in.axi_cd, follow_in.axi_cd, IS_HIDDEN && MON_AXI_CD);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign trace_out   = st_q.trace;
    assign core_in     = st_q.core;
    assign primary_out = st_q.prim;
    assign compare_out = st_q.cmp;

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    assign shadow_core_param    = IS_SHADOW;
    assign exposed_as_processor = !IS_HIDDEN;
    assign cache_bus_ace        = BUS_SEL == BUS_ACE && ACE_OK;
    assign ace_config_error     = BUS_SEL == BUS_ACE && !ACE_OK;
    assign periph_full_axi4     = EXCLUSIVE_ACCESS;
    assign vectors_on_local_memory_bus = DATA_LOCAL_MEMORY_BUS_EN;

    // ----------------------------------------
    // Stream link pairs
    // ----------------------------------------
    for (genvar i = 0; i < STREAM_LINKS; i++) begin : g_link
        ctlp_stage #(.W (XLEN)) u_master (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .in_valid  (put_valid[i]),
            .in_data   (put_data[i]),
            .in_ready  (put_ready[i]),
            .out_valid (m_axis_tvalid[i]),
            .out_data  (m_axis_tdata[i]),
            .out_ready (m_axis_tready[i])
        );
        ctlp_stage #(.W (XLEN)) u_slave (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .in_valid  (s_axis_tvalid[i]),
            .in_data   (s_axis_tdata[i]),
            .in_ready  (s_axis_tready[i]),
            .out_valid (get_valid[i]),
            .out_data  (get_data[i]),
            .out_ready (get_ready[i])
        );
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_pop;
        fifo_valid && trace_ready;
    endsequence

    a_retired_program_counter_qual: assert property (!trace_out.valid |-> trace_out.pc == '0 && trace_out.instr == '0)
        else $error("pc shown without retire valid");
    a_trace_addr_qual: assert property (!(trace_out.rd || trace_out.wr) |-> trace_out.data_addr == '0)
        else $error("address shown without load or store");
    a_trace_reg_qual: assert property (!trace_out.reg_wr |-> trace_out.reg_idx == '0 && trace_out.reg_val == '0)
        else $error("register shown without write strobe");
    a_trace_exc_qual: assert property (!trace_out.exc_taken |-> trace_out.exc_kind == '0)
        else $error("exception kind shown without taken flag");
    a_trace_follows: assert property (seq_pop |=> trace_out == $past(fifo_data))
        else $error("trace record lost on pop");
    a_trace_idle: assert property (!(fifo_valid && trace_ready) |=> trace_out == '0)
        else $error("trace strobes held without pop");
    a_none_silent: assert property (LS_MODE == LS_NONE |-> primary_out == '0 && compare_out == '0)
        else $error("lockstep port active while off");
    a_primary_copy: assert property (LS_MODE == LS_PRIMARY |=> primary_out == $past(own_in))
        else $error("primary bundle not a copy of inputs");
    a_cmp_valid: assert property (LS_MODE != LS_NONE && retire_in.valid && retire_ready |=> compare_out.valid
        && compare_out.pc == $past(retire_in.pc))
        else $error("compare bundle missed a retire");
    a_shadow_param: assert property (shadow_core_param |-> primary_out == '0)
        else $error("shadow drives the primary bundle");
    a_irq_monitor: assert property (IS_SHADOW && MON_IRQ |=> core_in.irq == $past(follow_in.irq))
        else $error("shadow interrupt not from primary");
    a_local_bus_monitor: assert property (IS_HIDDEN && MON_LOCAL_MEMORY_BUS_D
        |=> core_in.local_memory_bus_d == $past(follow_in.local_memory_bus_d))
        else $error("shadow local data not from primary");
endmodule
